// ==== src/ela_pkg.sv ====
// Constants and types shared by the logic analyzer capture block.
// Notes on behaviour
// - One sample is taken on each rising edge of the acquisition clock while the clock enable is high.
// - There is no way to sample on the falling edge of that clock.
// - The acquisition clock, reset, clock enable and host port must be connected; the probe inputs may idle.
// - The probe bus, of configured width, is what the buffer records.
// - Trigger levels look only at a separate trigger bus of its own width.
// - With its option on, the external trigger input fires a trigger.
// - With its option on, the trigger output pulses on the trigger event.
// - With qualification on, a sample is stored only while enabled.
// - Depth, memory kind, widths, levels and options are build constants.
// - Each trigger level is basic or advanced, chosen per level.
// - Nothing triggers out of reset; the analyzer waits to be armed.
// - Once running, capture is continuous until the post-trigger count after the trigger runs out or the host stops it.
// - Arming, trigger watching and readout are driven by the host.
package ela_pkg;

    // Build-time shape
    localparam int DATA_W       = 8;
    localparam int TRIG_W       = 4;
    localparam int SAMPLE_DEPTH = 64;
    localparam int PTR_W        = 6;
    localparam int TRIG_LEVELS  = 2;
    localparam int LVL_W        = 1;
    localparam int FIFO_DEPTH   = 16;
    localparam int ADDR_W       = 4;
    localparam int REG_W        = 16;

    // Build-time options; qualification is dropped for segmented buffers
    localparam bit TRIG_IN_EN   = 1'b1;
    localparam bit TRIG_OUT_EN  = 1'b1;
    localparam bit SEGMENTED    = 1'b0;
    localparam bit STORAGE_QUAL = 1'b1;
    localparam bit QUAL_ALLOWED = STORAGE_QUAL & ~SEGMENTED;
    // Memory style selector; only a plain register array is built
    localparam logic [3:0] RAM_KIND = 4'h0;

    // Register indices
    localparam logic [ADDR_W-1:0] ADDR_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_LVL0   = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_POST   = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_TPOS   = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_RDATA  = 4'h6;

    // Control bits
    localparam int CTRL_ARM  = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_READ = 2;
    localparam int CTRL_TOUT = 3;
    localparam int CTRL_TIN  = 4;
    localparam int CTRL_QUAL = 5;

    // Trigger level layout: mask, value, advanced flag
    localparam int LVL_MASK_LSB = 0;
    localparam int LVL_VAL_LSB  = 4;
    localparam int LVL_ADV_BIT  = 8;

    // Read data flag for a valid buffer word
    localparam int RD_VALID_BIT = 15;

    // Reset values and steps
    localparam logic [PTR_W-1:0] PTR_ZERO  = 6'h00;
    localparam logic [PTR_W-1:0] PTR_ONE   = 6'h01;
    localparam logic [PTR_W-1:0] POST_RST  = 6'h20;
    localparam logic [PTR_W:0]   DEPTH_CNT = 7'h40;
    localparam logic [PTR_W:0]   CNT_ONE   = 7'h01;
    localparam logic [LVL_W-1:0] LVL_LAST  = 1'h1;
    localparam logic [LVL_W-1:0] LVL_ONE   = 1'h1;

    typedef enum logic [1:0] {
        ELA_IDLE = 2'b00,
        ELA_RUN  = 2'b01,
        ELA_POST = 2'b11,
        ELA_DONE = 2'b10
    } ela_state_t;

endpackage

// ==== src/ela_fifo.sv ====
// Readout FIFO between the acquisition buffer and the register port.
`timescale 1ns/1ns
module ela_fifo
    import ela_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
)(
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    input  wire logic             ce_i,
    // Fill side
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    // Drain side
    output logic                  out_valid_o,
    output logic [WIDTH-1:0]      out_data_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } ela_fifo_t;

    ela_fifo_t        s_reg;
    ela_fifo_t        s_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign in_ready_o  = (s_reg.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (s_reg.cnt != '0);
    assign out_data_o  = mem[s_reg.rp];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_ready_i && out_valid_o;

    always_comb
    begin
        s_next = s_reg;
        if (push)
        begin
            s_next.wp = s_reg.wp + AW'(1);
        end
        if (pop)
        begin
            s_next.rp = s_reg.rp + AW'(1);
        end
        s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s_reg <= '0;
        end
        else if (ce_i)
        begin
            s_reg <= s_next;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (ce_i && push)
        begin
            mem[s_reg.wp] <= in_data_i;
        end
    end
endmodule

// ==== src/ela_capture.sv ====
// Capture front end of the embedded logic analyzer.
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ns
module ela_capture
    import ela_pkg::*;
(
    // Clock, enable and reset
    input  wire logic              clk_i,
    input  wire logic              ce_i,
    input  wire logic              nrst_i,
    // Probed design signals
    input  wire logic [DATA_W-1:0] acq_data_i,
    input  wire logic [TRIG_W-1:0] acq_trig_i,
    input  wire logic              trig_in_i,
    input  wire logic              store_en_i,
    output logic                   trigger_out_o,
    // Host register port
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [REG_W-1:0]  wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic [REG_W-1:0]       rd_data_o
);

    typedef struct packed {
        ela_state_t                        state;
        logic [PTR_W-1:0]                  wr_ptr;
        logic [PTR_W-1:0]                  trig_pos;
        logic [PTR_W-1:0]                  post_left;
        logic [PTR_W-1:0]                  post_cfg;
        logic [LVL_W-1:0]                  stage;
        logic                              triggered;
        logic                              tout_en;
        logic                              tin_en;
        logic                              qual_en;
        logic [TRIG_LEVELS-1:0][REG_W-1:0] lvl;
        logic                              trig_out;
        logic                              rd_active;
        logic [PTR_W-1:0]                  rd_ptr;
        logic [PTR_W:0]                    rd_left;
        logic [REG_W-1:0]                  rdata;
    } ela_cap_t;

    ela_cap_t          s_reg;
    ela_cap_t          s_next;
    logic [DATA_W-1:0] mem [SAMPLE_DEPTH];
    logic              mem_we;
    logic [TRIG_LEVELS-1:0] lvl_hit;
    logic              cur_hit;
    logic              ext_hit;
    logic              fire;
    logic              qual_ok;
    logic              arm;
    logic              stop;
    logic              read_go;
    logic              fifo_push;
    logic              fifo_pop;
    logic              fifo_in_ready;
    logic              fifo_out_valid;
    logic [DATA_W-1:0] fifo_out_data;

    ////////////////////////////////////////////////////////////////////////
    // Trigger level evaluation

    // Basic needs every masked bit to match; advanced accepts any of them
    function automatic logic lvl_match(input logic [REG_W-1:0]  cfg,
                                       input logic [TRIG_W-1:0] t);
        logic [TRIG_W-1:0] mask;
        logic [TRIG_W-1:0] eq;
        mask = cfg[LVL_MASK_LSB +: TRIG_W];
        eq   = ~(t ^ cfg[LVL_VAL_LSB +: TRIG_W]);
        if (cfg[LVL_ADV_BIT])
        begin
            lvl_match = |(mask & eq);
        end
        else
        begin
            lvl_match = &(eq | ~mask);
        end
    endfunction

    for (genvar g = 0; g < TRIG_LEVELS; g++)
    begin : g_lvl
        assign lvl_hit[g] = lvl_match(s_reg.lvl[g], acq_trig_i);
    end

    assign cur_hit = lvl_hit[s_reg.stage];
    assign ext_hit = TRIG_IN_EN && s_reg.tin_en && trig_in_i;
    assign fire    = (cur_hit && (s_reg.stage == LVL_LAST)) || ext_hit;
    assign qual_ok = !(QUAL_ALLOWED && s_reg.qual_en) || store_en_i;

    assign arm     = wr_i && (addr_i == ADDR_CTRL) && wdata_i[CTRL_ARM];
    assign stop    = wr_i && (addr_i == ADDR_CTRL) && wdata_i[CTRL_STOP];
    assign read_go = wr_i && (addr_i == ADDR_CTRL) && wdata_i[CTRL_READ];

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        s_next    = s_reg;
        mem_we    = 1'b0;
        fifo_push = 1'b0;
        fifo_pop  = 1'b0;
        s_next.trig_out = 1'b0;
        s_next.rdata    = '0;

        // Host writes to configuration
        if (wr_i)
        begin
            if (addr_i == ADDR_CTRL)
            begin
                s_next.tout_en = wdata_i[CTRL_TOUT];
                s_next.tin_en  = wdata_i[CTRL_TIN];
                s_next.qual_en = wdata_i[CTRL_QUAL];
            end
            if (addr_i == ADDR_POST)
            begin
                s_next.post_cfg = wdata_i[PTR_W-1:0];
            end
            for (int i = 0; i < TRIG_LEVELS; i++)
            begin
                if (addr_i == ADDR_LVL0 + ADDR_W'(i))
                begin
                    s_next.lvl[i] = wdata_i;
                end
            end
        end

        case (s_reg.state)
            ELA_IDLE, ELA_DONE:
            begin
                if (arm)
                begin
                    s_next.state     = ELA_RUN;
                    s_next.wr_ptr    = PTR_ZERO;
                    s_next.stage     = '0;
                    s_next.triggered = 1'b0;
                    s_next.rd_active = 1'b0;
                end
                else if (read_go && (s_reg.state == ELA_DONE))
                begin
                    // Oldest sample sits at the write pointer after a wrap
                    s_next.rd_active = 1'b1;
                    s_next.rd_ptr    = s_reg.wr_ptr;
                    s_next.rd_left   = DEPTH_CNT;
                end
            end
            ELA_RUN:
            begin
                if (stop)
                begin
                    s_next.state = ELA_IDLE;
                end
                else
                begin
                    mem_we = qual_ok;
                    if (qual_ok)
                    begin
                        s_next.wr_ptr = s_reg.wr_ptr + PTR_ONE;
                    end
                    if (fire)
                    begin
                        s_next.state     = ELA_POST;
                        s_next.trig_pos  = s_reg.wr_ptr;
                        s_next.triggered = 1'b1;
                        s_next.post_left = s_reg.post_cfg;
                        s_next.trig_out  = TRIG_OUT_EN && s_reg.tout_en;
                    end
                    else if (cur_hit)
                    begin
                        s_next.stage = s_reg.stage + LVL_ONE;
                    end
                end
            end
            ELA_POST:
            begin
                if (stop)
                begin
                    s_next.state = ELA_IDLE;
                end
                else if (s_reg.post_left == PTR_ZERO)
                begin
                    s_next.state = ELA_DONE;
                end
                else if (qual_ok)
                begin
                    mem_we           = 1'b1;
                    s_next.wr_ptr    = s_reg.wr_ptr + PTR_ONE;
                    s_next.post_left = s_reg.post_left - PTR_ONE;
                end
            end
            default:
            begin
                s_next.state = ELA_IDLE;
            end
        endcase

        if (s_reg.rd_active && (s_reg.state == ELA_DONE) && !arm)
        begin
            fifo_push = 1'b1;
            if (fifo_in_ready)
            begin
                s_next.rd_ptr  = s_reg.rd_ptr + PTR_ONE;
                s_next.rd_left = s_reg.rd_left - CNT_ONE;
                if (s_reg.rd_left == CNT_ONE)
                begin
                    s_next.rd_active = 1'b0;
                end
            end
        end

        // Register reads answer one cycle later
        if (rd_i)
        begin
            case (addr_i)
                ADDR_CTRL:
                begin
                    s_next.rdata = REG_W'({s_reg.qual_en, s_reg.tin_en,
                                           s_reg.tout_en, 3'h0});
                end
                ADDR_STATUS:
                begin
                    s_next.rdata = REG_W'({s_reg.rd_active, fifo_out_valid,
                                           s_reg.triggered, s_reg.state});
                end
                ADDR_POST:
                begin
                    s_next.rdata = REG_W'(s_reg.post_cfg);
                end
                ADDR_TPOS:
                begin
                    s_next.rdata = REG_W'(s_reg.trig_pos);
                end
                ADDR_RDATA:
                begin
                    // Reading pops one word; an empty FIFO reads as zero
                    fifo_pop = fifo_out_valid;
                    s_next.rdata = fifo_out_valid ? REG_W'(fifo_out_data) : '0;
                    s_next.rdata[RD_VALID_BIT] = fifo_out_valid;
                end
                default:
                begin
                    for (int i = 0; i < TRIG_LEVELS; i++)
                    begin
                        if (addr_i == ADDR_LVL0 + ADDR_W'(i))
                        begin
                            s_next.rdata = s_reg.lvl[i];
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers and sample memory

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s_reg           <= '0;
            s_reg.post_cfg  <= POST_RST;
        end
        else if (ce_i)
        begin
            s_reg <= s_next;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (ce_i && mem_we)
        begin
            mem[s_reg.wr_ptr] <= acq_data_i;
        end
    end

    // The FIFO lets the host drain slowly; a full FIFO stalls the readout
    ela_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .nrst_i      (nrst_i),
        .ce_i        (ce_i),
        .in_valid_i  (fifo_push),
        .in_data_i   (mem[s_reg.rd_ptr]),
        .in_ready_o  (fifo_in_ready),
        .out_valid_o (fifo_out_valid),
        .out_data_o  (fifo_out_data),
        .out_ready_i (fifo_pop)
    );

    assign trigger_out_o = s_reg.trig_out;
    assign rd_data_o     = s_reg.rdata;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    a_sample_advance: assert property (
        ce_i && s_reg.state == ELA_RUN && !stop && qual_ok
        |=> s_reg.wr_ptr == $past(s_reg.wr_ptr) + PTR_ONE)
        else $error("write pointer did not advance on a sample");
    a_qual_hold: assert property (
        ce_i && s_reg.state == ELA_RUN && s_reg.qual_en && !store_en_i
        |=> s_reg.wr_ptr == $past(s_reg.wr_ptr))
        else $error("sample stored while qualifier low");
    a_ext_fires: assert property (
        ce_i && s_reg.state == ELA_RUN && !stop && s_reg.tin_en
        && trig_in_i |=> s_reg.state == ELA_POST && s_reg.triggered)
        else $error("external trigger ignored");
    a_tout_pulse: assert property (
        ce_i && s_reg.state == ELA_RUN && !stop && fire && s_reg.tout_en
        |=> trigger_out_o ##1 (!trigger_out_o || $past(fire)))
        else $error("trigger output not pulsed on trigger");
    a_tout_quiet: assert property (
        trigger_out_o && $past(ce_i) |-> $past(s_reg.state) == ELA_RUN)
        else $error("trigger output outside a trigger");
    a_idle_wait: assert property (
        s_reg.state == ELA_IDLE && !arm |=> s_reg.state == ELA_IDLE)
        else $error("left idle without arming");
    a_post_end: assert property (
        ce_i && s_reg.state == ELA_POST && !stop
        && s_reg.post_left == PTR_ZERO |=> s_reg.state == ELA_DONE)
        else $error("post trigger count did not end capture");
    a_done_frozen: assert property (
        s_reg.state == ELA_DONE |-> !mem_we)
        else $error("buffer written after capture ended");
    a_level_order: assert property (
        ce_i && s_reg.state == ELA_RUN && s_reg.stage == '0 && !ext_hit
        && !stop |=> s_reg.state == ELA_RUN)
        else $error("trigger fired before the first level");
    a_read_stall: assert property (
        s_reg.rd_active && !fifo_in_ready
        |=> s_reg.rd_ptr == $past(s_reg.rd_ptr))
        else $error("readout advanced into a full FIFO");

    c_trigger: cover property (s_reg.state == ELA_RUN ##1
        s_reg.state == ELA_POST);
    c_ext_trig: cover property (ext_hit && s_reg.state == ELA_RUN);
    c_fifo_full: cover property (s_reg.rd_active && !fifo_in_ready);
    c_readout: cover property (rd_i && addr_i == ADDR_RDATA
        && fifo_out_valid);

endmodule

// ==== dv/ela_probe_model.sv ====
// Probe source standing in for the user logic under debug.
`timescale 1ns/1ns
module ela_probe_model
    import ela_pkg::*;
(
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         nrst_i,
    // Request from the bench
    input  wire logic         fire_i,
    // Probed signals
    output logic [DATA_W-1:0] acq_data_o,
    output logic [TRIG_W-1:0] acq_trig_o,
    output logic              trig_in_o,
    output logic              store_en_o,
    // Data value present when the external trigger was sampled
    output logic [DATA_W-1:0] trig_data_o
);
    ////////////////////////////////////////////////////////////////////////
    // Clocked probe drive
    // Counting data makes every stored word predictable from its neighbour
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            acq_data_o  <= 8'h00;
            trig_in_o   <= 1'b0;
            trig_data_o <= 8'h00;
        end
        else
        begin
            acq_data_o <= acq_data_o + 8'h01;
            trig_in_o  <= fire_i;
            if (trig_in_o)
            begin
                trig_data_o <= acq_data_o;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Derived probe lines
    // Both come from the same register, so they are stable at each edge
    assign acq_trig_o = acq_data_o[TRIG_W-1:0];
    assign store_en_o = acq_data_o[0];
endmodule

// ==== dv/testbench.sv ====
// Self-checking bench for the analyzer capture front end.
`timescale 1ns/1ns
module testbench
    import ela_pkg::*;
;
    logic              clk_i       = 1'b0;
    logic              nrst_i      = 1'b0;
    logic              ce_i        = 1'b1;
    logic              fire        = 1'b0;
    logic [ADDR_W-1:0] addr_i      = 4'h0;
    logic [REG_W-1:0]  wdata_i     = 16'h0000;
    logic              wr_i        = 1'b0;
    logic              rd_i        = 1'b0;
    logic              expect_fire = 1'b0;
    logic              tin_d       = 1'b0;
    logic [DATA_W-1:0] acq_data;
    logic [TRIG_W-1:0] acq_trig;
    logic              trig_in;
    logic              store_en;
    logic [DATA_W-1:0] trig_data;
    logic              trigger_out_o;
    logic [REG_W-1:0]  rd_data_o;
    logic [DATA_W-1:0] d1;
    logic [DATA_W-1:0] last;
    int                error_cnt   = 0;
    int                cmp_count   = 0;
    int                pulses      = 0;

    always #50 clk_i = ~clk_i;

    ela_capture DUT
    (
        .clk_i         (clk_i),
        .ce_i          (ce_i),
        .nrst_i        (nrst_i),
        .acq_data_i    (acq_data),
        .acq_trig_i    (acq_trig),
        .trig_in_i     (trig_in),
        .store_en_i    (store_en),
        .trigger_out_o (trigger_out_o),
        .addr_i        (addr_i),
        .wdata_i       (wdata_i),
        .wr_i          (wr_i),
        .rd_i          (rd_i),
        .rd_data_o     (rd_data_o)
    );

    ela_probe_model probe
    (
        .clk_i       (clk_i),
        .nrst_i      (nrst_i),
        .fire_i      (fire),
        .acq_data_o  (acq_data),
        .acq_trig_o  (acq_trig),
        .trig_in_o   (trig_in),
        .store_en_o  (store_en),
        .trig_data_o (trig_data)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        #1;
        v = rd_data_o;
    endtask

    task automatic rcm(input logic [3:0] a, input logic [15:0] m,
                       input logic [15:0] e);
        logic [15:0] v;
        rd(a, v);
        check(v & m, e);
    endtask

    task automatic pulse();
        @(posedge clk_i);
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
    endtask

    // Lets the FIFO fill until it stalls, then drains all 64 words
    task automatic readout(input logic [15:0] ctrl, input logic [7:0] step,
                           output logic [7:0] lastw);
        logic [15:0] v;
        logic [7:0]  prev;
        int          n;
        n = 0;
        prev = 8'h00;
        wr(ADDR_CTRL, ctrl | 16'h0004);
        repeat (25) @(posedge clk_i);
        rcm(ADDR_STATUS, 16'h0018, 16'h0018);
        for (int i = 0; i < 300 && n < 64; i++)
        begin
            rd(ADDR_RDATA, v);
            if (v[RD_VALID_BIT] === 1'b1)
            begin
                if (n > 0)
                    check({8'h00, v[7:0]}, {8'h00, prev + step});
                prev = v[7:0];
                n++;
            end
        end
        check(n[15:0], 16'h0040);
        rcm(ADDR_RDATA, 16'hffff, 16'h0000);
        lastw = prev;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Trigger output one edge after each sampled external trigger must match expect_fire
    always @(posedge clk_i)
    begin
        if (tin_d !== 1'b0)
            check(16'(trigger_out_o), 16'(expect_fire));
        if (trigger_out_o === 1'b1)
            pulses++;
        tin_d <= trig_in;
    end

    initial
    begin
        repeat (6000) @(posedge clk_i);
        error_cnt++;
        summarize();
    end

    initial
    begin
        repeat (12) @(posedge clk_i);
        nrst_i <= 1'b1;
        rcm(ADDR_STATUS, 16'hffff, 16'h0000);
        rcm(ADDR_POST, 16'hffff, 16'h0020);
        rcm(ADDR_LVL0, 16'hffff, 16'h0000);
        rcm(4'hf, 16'hffff, 16'h0000);
        // Writes while the clock enable is low are lost
        ce_i <= 1'b0;
        wr(ADDR_POST, 16'h0011);
        ce_i <= 1'b1;
        rcm(ADDR_POST, 16'hffff, 16'h0020);
        pulse();
        repeat (3) @(posedge clk_i);
        rcm(ADDR_STATUS, 16'h0007, 16'h0000);
        // Advanced levels with an empty mask never hit
        wr(ADDR_LVL0, 16'h0100);
        wr(ADDR_LVL0 + 4'h1, 16'h0100);
        wr(ADDR_POST, 16'h0003);
        rcm(ADDR_LVL0 + 4'h1, 16'hffff, 16'h0100);
        wr(ADDR_CTRL, 16'h0001);
        repeat (20) @(posedge clk_i);
        rcm(ADDR_STATUS, 16'h0007, 16'h0001);
        wr(ADDR_CTRL, 16'h0002);
        rcm(ADDR_STATUS, 16'h0003, 16'h0000);
        // External trigger after the buffer has wrapped
        wr(ADDR_CTRL, 16'h0019);
        #1;
        d1 = acq_data;
        repeat (100) @(posedge clk_i);
        expect_fire = 1'b1;
        pulse();
        repeat (10) @(posedge clk_i);
        rcm(ADDR_STATUS, 16'h0007, 16'h0006);
        rcm(ADDR_TPOS, 16'h003f, 16'(6'(trig_data - d1)));
        readout(16'h0018, 8'h01, last);
        check({8'h00, last}, {8'h00, trig_data + 8'h03});
        // Basic level then advanced level, trigger output off
        expect_fire = 1'b0;
        wr(ADDR_LVL0, 16'h005f);
        wr(ADDR_LVL0 + 4'h1, 16'h0101);
        wr(ADDR_POST, 16'h0000);
        wr(ADDR_CTRL, 16'h0001);
        #1;
        d1 = acq_data;
        repeat (30) @(posedge clk_i);
        rcm(ADDR_STATUS, 16'h0007, 16'h0006);
        rcm(ADDR_TPOS, 16'h3f, 16'(4'(4'h5 - d1[3:0])) + 16'h1);
        // Qualified storage keeps only the odd samples
        wr(ADDR_LVL0, 16'h0100);
        wr(ADDR_LVL0 + 4'h1, 16'h0100);
        wr(ADDR_POST, 16'h0003);
        wr(ADDR_CTRL, 16'h0031);
        repeat (200) @(posedge clk_i);
        pulse();
        repeat (20) @(posedge clk_i);
        rcm(ADDR_STATUS, 16'h0007, 16'h0006);
        readout(16'h0030, 8'h02, last);
        check({15'h0000, last[0]}, 16'h0001);
        check(pulses[15:0], 16'h0001);
        summarize();
    end
endmodule
